// *** core/tdf_map.svh ***
`ifndef TDF_MAP_SVH
`define TDF_MAP_SVH

// ==========================================================================
// Clock and timing
// ==========================================================================
`define TDF_CLK_MHZ 200
`define TDF_PLM_MAX_MS 100
`define TDF_PLM_MAX_CYC (`TDF_PLM_MAX_MS * 1000 * `TDF_CLK_MHZ)

// ==========================================================================
// Persistence counts
// ==========================================================================
`define TDF_ALIGN_IN_CNT 3'h3
`define TDF_ALIGN_OUT_CNT 3'h5
`define TDF_AIS_FRAMES 3'h3
`define TDF_DEG_M_MIN 4'h2
`define TDF_DEG_M_MAX 4'hA
`define TDF_LBL_M_MIN 4'h3
`define TDF_LBL_M_MAX 4'hA

// ==========================================================================
// Label codes and reset values
// ==========================================================================
`define TDF_LBL_NONSPEC 8'h01
`define TDF_LBL_RST 8'h00
`define TDF_CNT_RST 4'h0
`define TDF_RUN_RST 3'h0

`endif

// *** core/tdf_pkg.sv ***
package tdf_pkg;

  // ========================================================================
  // Types
  // ========================================================================
  typedef enum logic {align_oof, align_in} tdf_align_e;
  typedef logic [3:0] tdf_cnt_t;
  typedef logic [7:0] tdf_label_t;

  // Limits a provisioned count to its supported range.
  function automatic tdf_cnt_t tdf_clamp(input tdf_cnt_t v, input tdf_cnt_t lo,
                                         input tdf_cnt_t hi);
    tdf_cnt_t r;
    r = v;
    if (v < lo) begin
      r = lo;
    end else if (v > hi) begin
      r = hi;
    end
    return r;
  endfunction

endpackage

// *** core/tdf_persist.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "tdf_map.svh"

module tdf_persist
  import tdf_pkg::*;
#(
  parameter logic [2:0] IN_CNT = `TDF_ALIGN_IN_CNT,
  parameter logic [2:0] OUT_CNT = `TDF_ALIGN_OUT_CNT
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic clk_en,
  // Observations
  input wire logic opp,
  input wire logic loss_anomaly,
  // Defect
  output logic out_of_alignment_state
);

  // ========================================================================
  // State
  // ========================================================================
  tdf_align_e state_ff;
  tdf_align_e nxt_state;
  logic [2:0] run_ff;
  logic [2:0] nxt_run;
  logic oof_ff;
  wire logic [2:0] run_inc = run_ff + 3'h1;

  always_comb begin
    nxt_state = state_ff;
    nxt_run = run_ff;
    if (opp) begin
      unique case (state_ff)
        align_oof: begin
          if (loss_anomaly) begin
            nxt_run = `TDF_RUN_RST;
          end else if (run_inc == IN_CNT) begin
            nxt_state = align_in;
            nxt_run = `TDF_RUN_RST;
          end else begin
            nxt_run = run_inc;
          end
        end
        align_in: begin
          if (!loss_anomaly) begin
            nxt_run = `TDF_RUN_RST;
          end else if (run_inc == OUT_CNT) begin
            nxt_state = align_oof;
            nxt_run = `TDF_RUN_RST;
          end else begin
            nxt_run = run_inc;
          end
        end
      endcase
    end
  end

  // Reset lands in out-of-alignment, so the defect starts asserted.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= align_oof;
      run_ff <= `TDF_RUN_RST;
      oof_ff <= 1'b1;
    end else if (clk_en) begin
      state_ff <= nxt_state;
      run_ff <= nxt_run;
      oof_ff <= (nxt_state == align_oof);
    end
  end

  assign out_of_alignment_state = oof_ff;

  // ========================================================================
  // Checks
  // ========================================================================
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  chk_enter_in: assert property (
    clk_en && opp && !loss_anomaly && state_ff == align_oof && run_ff == IN_CNT - 3'h1
    |=> !oof_ff && state_ff == align_in)
    else $error("alignment not entered after clean run");

  chk_leave_in: assert property (
    clk_en && opp && loss_anomaly && state_ff == align_in && run_ff == OUT_CNT - 3'h1
    |=> oof_ff && state_ff == align_oof)
    else $error("alignment not left after lossy run");

  chk_run_break: assert property (
    clk_en && opp && (loss_anomaly == (state_ff == align_oof)) |=> run_ff == 3'h0)
    else $error("run not cleared by opposite observation");

  chk_defect_state: assert property (
    oof_ff == (state_ff == align_oof))
    else $error("defect does not match state");

endmodule

`default_nettype wire

// *** core/tdf_label.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "tdf_map.svh"

module tdf_label
  import tdf_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic clk_en,
  // Received label
  input wire logic label_frame,
  input wire tdf_label_t path_signal_label,
  input wire tdf_label_t expected_label,
  input wire tdf_cnt_t label_m,
  // Result
  output tdf_label_t accepted_label,
  output logic payload_mismatch_anomaly
);

  tdf_label_t cand_ff;
  tdf_label_t acc_ff;
  tdf_cnt_t rep_ff;
  logic plm_ff;
  wire tdf_cnt_t m_eff = tdf_clamp(label_m, `TDF_LBL_M_MIN, `TDF_LBL_M_MAX);
  wire logic same = (path_signal_label == cand_ff) && (rep_ff != `TDF_CNT_RST);
  wire tdf_cnt_t rep_inc = (rep_ff >= m_eff) ? rep_ff : rep_ff + 4'h1;
  wire tdf_cnt_t nxt_rep = label_frame ? (same ? rep_inc : 4'h1) : rep_ff;
  wire tdf_label_t nxt_acc = (label_frame && nxt_rep >= m_eff) ? path_signal_label : acc_ff;
  // The non-specific code matches every expected code.
  wire logic nxt_plm = (nxt_acc != expected_label) && (nxt_acc != `TDF_LBL_NONSPEC);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cand_ff <= `TDF_LBL_RST;
      acc_ff <= `TDF_LBL_RST;
      rep_ff <= `TDF_CNT_RST;
      plm_ff <= 1'b0;
    end else if (clk_en) begin
      cand_ff <= label_frame ? path_signal_label : cand_ff;
      acc_ff <= nxt_acc;
      rep_ff <= nxt_rep;
      plm_ff <= nxt_plm;
    end
  end

  assign accepted_label = acc_ff;
  assign payload_mismatch_anomaly = plm_ff;

  // ========================================================================
  // Checks
  // ========================================================================
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  chk_label_accept: assert property (
    clk_en && label_frame && same && rep_ff + 4'h1 >= m_eff
    |=> acc_ff == $past(path_signal_label))
    else $error("repeated label not accepted");

  chk_label_hold: assert property (
    clk_en && label_frame && !same && m_eff > 4'h1 |=> $stable(acc_ff))
    else $error("label accepted on first sight");

  chk_nonspec_match: assert property (
    clk_en && nxt_acc == `TDF_LBL_NONSPEC |=> !plm_ff)
    else $error("non-specific code flagged as mismatch");

endmodule

`default_nettype wire

// *** core/tdf_top.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "tdf_map.svh"

// Overview of operation
// - Signal-loss defect follows the signal-loss anomaly.
// - Block-error defect set when any block-error anomaly occurs in the block.
// - Degraded defect raised after M consecutive bad seconds.
// - Active degraded defect cleared after M consecutive good seconds.
// - M is provisioned from 2 to 10; the whole range is supported.
// - Server fail or alarm defect forces degraded off and resets counting.
// - Degraded window restarts whenever the second's sense changes.
// - Frame machine enters alignment after three clean opportunities.
// - Frame machine leaves alignment after five lossy opportunities.
// - Frame-loss defect is asserted while the frame machine is out of alignment.
// - Both machines start out of alignment after reset.
// - Justification machine enters alignment after three clean opportunities.
// - Justification machine leaves alignment after five lossy opportunities.
// - Justification-loss defect is asserted while its machine is out of alignment.
// - Line-coded framing makes frame-loss defect follow the anomaly directly.
// - Mismatch defect raised within 100 ms of mismatch onset.
// - Mismatch defect cleared within 100 ms of mismatch end.
// - Trail fail holds the mismatch defect off.
// - Otherwise the mismatch defect tracks the mismatch anomaly.
// - Alarm defect set after more than three consecutive alarmed frames.
// - Accepted label non-specific code always counts as matching.
// - New label accepted after m identical consecutive frames, m from 3 to 10.
module tdf_top
  import tdf_pkg::*;
#(
  parameter int PLM_MAX_CYC = `TDF_PLM_MAX_CYC
) (
  // Clock, reset and enable
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic clk_en,
  // Signal loss
  input wire logic signal_loss_anomaly,
  output logic signal_loss_defect,
  // Block errors
  input wire logic block_error_anomaly,
  input wire logic block_end,
  output logic block_error_defect,
  // Degraded signal
  input wire logic second_tick,
  input wire logic second_bad,
  input wire tdf_cnt_t deg_m,
  input wire logic server_fail_in,
  output logic degraded_defect,
  // Frame alignment
  input wire logic frame_opp,
  input wire logic frame_loss_anomaly,
  input wire logic line_coded_mode,
  output logic frame_loss_defect,
  // Justification alignment
  input wire logic justif_opp,
  input wire logic justif_loss_anomaly,
  output logic justif_loss_defect,
  // Payload label
  input wire logic label_frame,
  input wire tdf_label_t path_signal_label,
  input wire tdf_label_t expected_label,
  input wire tdf_cnt_t label_m,
  input wire logic trail_fail_in,
  output tdf_label_t accepted_label,
  output logic payload_mismatch_anomaly,
  output logic payload_mismatch_defect,
  // Alarm signal
  input wire logic ais_frame,
  input wire logic alarm_signal_anomaly,
  output logic alarm_signal_defect
);

  // ========================================================================
  // Signal loss and block errors
  // ========================================================================
  logic los_ff;
  logic err_seen_ff;
  logic blk_def_ff;

  // An anomaly in the closing cycle of a block still belongs to that block.
  wire logic blk_errored = err_seen_ff | block_error_anomaly;
  wire logic nxt_err_seen = block_end ? 1'b0 : blk_errored;
  wire logic nxt_blk_def = block_end ? blk_errored : blk_def_ff;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      los_ff <= 1'b0;
      err_seen_ff <= 1'b0;
      blk_def_ff <= 1'b0;
    end else if (clk_en) begin
      los_ff <= signal_loss_anomaly;
      err_seen_ff <= nxt_err_seen;
      blk_def_ff <= nxt_blk_def;
    end
  end

  // ========================================================================
  // Alarm signal
  // ========================================================================
  logic [2:0] ais_cnt_ff;
  logic ais_def_ff;

  wire logic ais_hit = ais_frame & alarm_signal_anomaly;
  wire logic ais_miss = ais_frame & !alarm_signal_anomaly;
  wire logic [2:0] ais_inc = (ais_cnt_ff > `TDF_AIS_FRAMES) ? ais_cnt_ff : ais_cnt_ff + 3'h1;
  wire logic [2:0] nxt_ais_cnt = ais_miss ? `TDF_RUN_RST : (ais_hit ? ais_inc : ais_cnt_ff);
  wire logic nxt_ais_def = ais_miss ? 1'b0 : (ais_hit ? (ais_inc > `TDF_AIS_FRAMES) : ais_def_ff);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ais_cnt_ff <= `TDF_RUN_RST;
      ais_def_ff <= 1'b0;
    end else if (clk_en) begin
      ais_cnt_ff <= nxt_ais_cnt;
      ais_def_ff <= nxt_ais_def;
    end
  end

  // ========================================================================
  // Degraded signal
  // ========================================================================
  logic deg_ff;
  logic run_bad_ff;
  tdf_cnt_t run_cnt_ff;

  // Out-of-range provisioning is pulled to the nearest supported value.
  wire tdf_cnt_t deg_m_eff = tdf_clamp(deg_m, `TDF_DEG_M_MIN, `TDF_DEG_M_MAX);
  wire logic deg_suppress = server_fail_in | ais_def_ff;
  wire logic same_sense = (second_bad == run_bad_ff) && (run_cnt_ff != `TDF_CNT_RST);
  wire tdf_cnt_t run_inc = (run_cnt_ff >= deg_m_eff) ? run_cnt_ff : run_cnt_ff + 4'h1;
  wire tdf_cnt_t run_step = same_sense ? run_inc : 4'h1;
  wire logic run_full = second_tick && (run_step >= deg_m_eff);
  wire tdf_cnt_t nxt_run_cnt = deg_suppress ? `TDF_CNT_RST :
                               (second_tick ? run_step : run_cnt_ff);
  wire logic nxt_run_bad = deg_suppress ? 1'b0 : (second_tick ? second_bad : run_bad_ff);
  wire logic nxt_deg = deg_suppress ? 1'b0 : (run_full ? second_bad : deg_ff);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      deg_ff <= 1'b0;
      run_bad_ff <= 1'b0;
      run_cnt_ff <= `TDF_CNT_RST;
    end else if (clk_en) begin
      deg_ff <= nxt_deg;
      run_bad_ff <= nxt_run_bad;
      run_cnt_ff <= nxt_run_cnt;
    end
  end

  // ========================================================================
  // Alignment persistence
  // ========================================================================
  logic frame_oof;
  logic frame_def_ff;

  tdf_persist #(
    .IN_CNT(`TDF_ALIGN_IN_CNT),
    .OUT_CNT(`TDF_ALIGN_OUT_CNT)
  ) u_frame (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .opp(frame_opp),
    .loss_anomaly(frame_loss_anomaly),
    .out_of_alignment_state(frame_oof)
  );

  tdf_persist #(
    .IN_CNT(`TDF_ALIGN_IN_CNT),
    .OUT_CNT(`TDF_ALIGN_OUT_CNT)
  ) u_justif (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .opp(justif_opp),
    .loss_anomaly(justif_loss_anomaly),
    .out_of_alignment_state(justif_loss_defect)
  );

  wire logic nxt_frame_def = line_coded_mode ? frame_loss_anomaly : frame_oof;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      frame_def_ff <= 1'b1;
    end else if (clk_en) begin
      frame_def_ff <= nxt_frame_def;
    end
  end

  // ========================================================================
  // Payload mismatch
  // ========================================================================
  logic plm_def_ff;

  tdf_label u_label (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .label_frame(label_frame),
    .path_signal_label(path_signal_label),
    .expected_label(expected_label),
    .label_m(label_m),
    .accepted_label(accepted_label),
    .payload_mismatch_anomaly(payload_mismatch_anomaly)
  );

  // One cycle from anomaly to defect keeps both 100 ms bounds with margin.
  wire logic nxt_plm_def = payload_mismatch_anomaly & !trail_fail_in;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      plm_def_ff <= 1'b0;
    end else if (clk_en) begin
      plm_def_ff <= nxt_plm_def;
    end
  end

  // ========================================================================
  // Outputs
  // ========================================================================
  assign signal_loss_defect = los_ff;
  assign block_error_defect = blk_def_ff;
  assign degraded_defect = deg_ff;
  assign frame_loss_defect = frame_def_ff;
  assign payload_mismatch_defect = plm_def_ff;
  assign alarm_signal_defect = ais_def_ff;

  // ========================================================================
  // Checks
  // ========================================================================
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  int plm_lag_cnt;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      plm_lag_cnt <= 0;
    end else if (plm_def_ff != (payload_mismatch_anomaly & !trail_fail_in)) begin
      plm_lag_cnt <= plm_lag_cnt + 1;
    end else begin
      plm_lag_cnt <= 0;
    end
  end

  sequence s_bad_close;
    second_tick && !deg_suppress && second_bad && run_step >= deg_m_eff;
  endsequence

  sequence s_good_close;
    second_tick && !deg_suppress && !second_bad && run_step >= deg_m_eff;
  endsequence

  chk_los_follow: assert property (
    clk_en |=> signal_loss_defect == $past(signal_loss_anomaly))
    else $error("signal-loss defect does not follow anomaly");

  chk_block_flag: assert property (
    clk_en && block_end |=> block_error_defect == $past(blk_errored))
    else $error("errored block not flagged");

  chk_deg_raise: assert property (
    clk_en and s_bad_close |=> degraded_defect)
    else $error("degraded not raised after bad run");

  chk_deg_clear: assert property (
    clk_en and s_good_close |=> !degraded_defect)
    else $error("degraded not cleared after good run");

  chk_m_range: assert property (
    deg_m_eff >= 4'h2 && deg_m_eff <= 4'hA)
    else $error("degraded window outside 2 to 10");

  chk_deg_suppress: assert property (
    clk_en && deg_suppress |=> !degraded_defect && run_cnt_ff == 4'h0)
    else $error("degraded not suppressed");

  chk_deg_restart: assert property (
    clk_en && second_tick && !deg_suppress && run_cnt_ff != 4'h0 &&
    second_bad != run_bad_ff |=> run_cnt_ff == 4'h1)
    else $error("degraded window not restarted");

  chk_deg_early: assert property (
    clk_en && second_tick && !deg_suppress && !degraded_defect && run_step < deg_m_eff
    |=> !degraded_defect)
    else $error("degraded raised before window full");

  chk_frame_direct: assert property (
    clk_en && line_coded_mode |=> frame_loss_defect == $past(frame_loss_anomaly))
    else $error("line-coded frame-loss not direct");

  chk_frame_state: assert property (
    clk_en && !line_coded_mode |=> frame_loss_defect == $past(frame_oof))
    else $error("frame-loss defect differs from machine");

  chk_plm_track: assert property (
    clk_en |=> payload_mismatch_defect == $past(payload_mismatch_anomaly && !trail_fail_in))
    else $error("mismatch defect not tracking");

  chk_plm_bound: assert property (
    plm_lag_cnt < PLM_MAX_CYC)
    else $error("mismatch defect late beyond bound");

  chk_ais_raise: assert property (
    clk_en && ais_hit && ais_cnt_ff == 3'h3 |=> alarm_signal_defect)
    else $error("alarm defect not raised on fourth frame");

  chk_ais_early: assert property (
    clk_en && ais_hit && ais_cnt_ff < 3'h3 && !alarm_signal_defect |=> !alarm_signal_defect)
    else $error("alarm defect raised too early");

  chk_ais_drop: assert property (
    clk_en && ais_miss |=> !alarm_signal_defect && ais_cnt_ff == 3'h0)
    else $error("alarm defect not dropped on clean frame");

  chk_freeze_hold: assert property (
    !clk_en |=> $stable(signal_loss_defect) && $stable(degraded_defect))
    else $error("state moved while clock enable low");

  chk_block_hold: assert property (
    clk_en && !block_end |=> $stable(block_error_defect))
    else $error("block result changed inside a block");

endmodule

`default_nettype wire

// *** tb/tdf_upstream.sv ***
`timescale 1ns/100ps
`default_nettype none

// ============================================================
// Upstream detector model
// ============================================================
// Channel 0 is frame alignment, 1 justification, 2 alarm frames.
// Outside a strobe each anomaly line shows the inverse of the
// requested sense, so a design that samples it there is caught.
module tdf_upstream (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Requests from the bench
  input wire logic [2:0] run,
  input wire logic [2:0] loss,
  input wire logic slow,
  // Strobes and anomalies
  output logic [2:0] opp,
  output logic [2:0] anomaly
);
  logic ph_ff;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ph_ff <= 1'b0;
    end else begin
      ph_ff <= ~ph_ff;
    end
  end

  // A slow detector offers an opportunity only every other cycle.
  assign opp = run & {3{~slow | ph_ff}};
  assign anomaly = loss ^ ~opp;
endmodule

`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import tdf_pkg::*;
  logic clk_sys, arst_n, clk_en, signal_loss_anomaly, block_error_anomaly, block_end;
  logic second_tick, second_bad, server_fail_in, line_coded_mode, label_frame;
  logic trail_fail_in, slow, signal_loss_defect, block_error_defect, degraded_defect;
  logic frame_loss_defect, justif_loss_defect, payload_mismatch_anomaly;
  logic payload_mismatch_defect, alarm_signal_defect;
  logic [2:0] run, loss, opp, anomaly;
  tdf_cnt_t deg_m, label_m;
  tdf_label_t path_signal_label, expected_label, accepted_label;
  int fail_count, n_tests;

  // ============================================================
  // Design and upstream model
  // ============================================================
  tdf_upstream u_up (.clk_sys(clk_sys), .arst_n(arst_n), .run(run), .loss(loss),
    .slow(slow), .opp(opp), .anomaly(anomaly));
  tdf_top #(.PLM_MAX_CYC(16)) u_dut (.clk_sys(clk_sys), .arst_n(arst_n), .clk_en(clk_en),
    .signal_loss_anomaly(signal_loss_anomaly), .signal_loss_defect(signal_loss_defect),
    .block_error_anomaly(block_error_anomaly), .block_end(block_end),
    .block_error_defect(block_error_defect), .second_tick(second_tick),
    .second_bad(second_bad), .deg_m(deg_m), .server_fail_in(server_fail_in),
    .degraded_defect(degraded_defect), .frame_opp(opp[0]), .frame_loss_anomaly(anomaly[0]),
    .line_coded_mode(line_coded_mode), .frame_loss_defect(frame_loss_defect),
    .justif_opp(opp[1]), .justif_loss_anomaly(anomaly[1]),
    .justif_loss_defect(justif_loss_defect), .label_frame(label_frame),
    .path_signal_label(path_signal_label), .expected_label(expected_label),
    .label_m(label_m), .trail_fail_in(trail_fail_in), .accepted_label(accepted_label),
    .payload_mismatch_anomaly(payload_mismatch_anomaly),
    .payload_mismatch_defect(payload_mismatch_defect), .ais_frame(opp[2]),
    .alarm_signal_anomaly(anomaly[2]), .alarm_signal_defect(alarm_signal_defect));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // ============================================================
  // Helpers
  // ============================================================
  task automatic chk_bit(input logic got, input logic exp, input string what);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic chk_lbl(input tdf_label_t got, input tdf_label_t exp, input string what);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic burst(input int ch, input logic l, input logic s, input int n);
    cyc(1);
    run[ch] = 1'b1;
    loss[ch] = l;
    slow = s;
    cyc(n);
    run[ch] = 1'b0;
  endtask

  task automatic tick(input logic bad, input int n);
    cyc(1);
    second_tick = 1'b1;
    second_bad = bad;
    cyc(n);
    second_tick = 1'b0;
  endtask

  task automatic lbl(input tdf_label_t v, input int n);
    cyc(1);
    label_frame = 1'b1;
    path_signal_label = v;
    cyc(n);
    label_frame = 1'b0;
  endtask

  task automatic look(input int ch, input logic exp);
    if (ch == 0) begin
      cyc(1);
    end
    chk_bit(ch == 0 ? frame_loss_defect : justif_loss_defect, exp, "alignment");
  endtask

  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ============================================================
  // Scenarios
  // ============================================================
  task automatic t_los;
    signal_loss_anomaly = 1'b1;
    cyc(1);
    chk_bit(signal_loss_defect, 1'b1, "los set");
    clk_en = 1'b0;
    signal_loss_anomaly = 1'b0;
    cyc(2);
    chk_bit(signal_loss_defect, 1'b1, "los frozen");
    clk_en = 1'b1;
    cyc(1);
    chk_bit(signal_loss_defect, 1'b0, "los clear");
  endtask

  task automatic t_blk;
    block_error_anomaly = 1'b1;
    cyc(1);
    block_error_anomaly = 1'b0;
    cyc(2);
    block_end = 1'b1;
    cyc(1);
    block_end = 1'b0;
    chk_bit(block_error_defect, 1'b1, "block errored");
    cyc(3);
    chk_bit(block_error_defect, 1'b1, "block held");
    block_end = 1'b1;
    cyc(1);
    chk_bit(block_error_defect, 1'b0, "block clean");
    block_error_anomaly = 1'b1;
    cyc(1);
    chk_bit(block_error_defect, 1'b1, "error at block end");
    block_end = 1'b0;
    block_error_anomaly = 1'b0;
  endtask

  task automatic t_deg;
    tdf_cnt_t ms[2] = '{4'h2, 4'hA};
    foreach (ms[i]) begin
      deg_m = ms[i];
      tick(1'b1, int'(ms[i]) - 1);
      chk_bit(degraded_defect, 1'b0, "deg early");
      tick(1'b1, 1);
      chk_bit(degraded_defect, 1'b1, "deg set");
      tick(1'b0, int'(ms[i]) - 1);
      chk_bit(degraded_defect, 1'b1, "deg held");
      tick(1'b0, 1);
      chk_bit(degraded_defect, 1'b0, "deg clear");
    end
    deg_m = 4'h2;
    tick(1'b1, 1);
    tick(1'b0, 1);
    tick(1'b1, 1);
    chk_bit(degraded_defect, 1'b0, "deg restart");
    tick(1'b1, 1);
    chk_bit(degraded_defect, 1'b1, "deg set again");
    server_fail_in = 1'b1;
    cyc(1);
    chk_bit(degraded_defect, 1'b0, "deg suppressed");
    tick(1'b1, 1);
    server_fail_in = 1'b0;
    tick(1'b1, 1);
    chk_bit(degraded_defect, 1'b0, "deg count reset");
    tick(1'b1, 1);
    chk_bit(degraded_defect, 1'b1, "deg after release");
  endtask

  task automatic t_align(input int ch);
    burst(ch, 1'b0, 1'b0, 2);
    look(ch, 1'b1);
    burst(ch, 1'b1, 1'b0, 1);
    burst(ch, 1'b0, 1'b0, 2);
    look(ch, 1'b1);
    burst(ch, 1'b0, 1'b1, 2);
    look(ch, 1'b0);
    burst(ch, 1'b1, 1'b0, 4);
    look(ch, 1'b0);
    burst(ch, 1'b0, 1'b0, 1);
    burst(ch, 1'b1, 1'b0, 4);
    look(ch, 1'b0);
    burst(ch, 1'b1, 1'b0, 1);
    look(ch, 1'b1);
  endtask

  task automatic t_line;
    cyc(1);
    line_coded_mode = 1'b1;
    run[0] = 1'b1;
    loss[0] = 1'b0;
    cyc(2);
    chk_bit(frame_loss_defect, 1'b0, "direct clear");
    loss[0] = 1'b1;
    cyc(1);
    chk_bit(frame_loss_defect, 1'b1, "direct set");
    line_coded_mode = 1'b0;
    run[0] = 1'b0;
  endtask

  task automatic t_ais;
    burst(2, 1'b1, 1'b0, 3);
    chk_bit(alarm_signal_defect, 1'b0, "ais three");
    burst(2, 1'b1, 1'b0, 1);
    chk_bit(alarm_signal_defect, 1'b1, "ais four");
    cyc(1);
    chk_bit(degraded_defect, 1'b0, "ais suppresses deg");
    burst(2, 1'b0, 1'b0, 1);
    chk_bit(alarm_signal_defect, 1'b0, "ais clear");
  endtask

  task automatic t_label;
    lbl(8'h13, 2);
    chk_lbl(accepted_label, 8'h00, "label early");
    lbl(8'h22, 1);
    lbl(8'h13, 3);
    chk_lbl(accepted_label, 8'h13, "label taken");
    chk_bit(payload_mismatch_anomaly, 1'b0, "label match");
    cyc(1);
    chk_bit(payload_mismatch_defect, 1'b0, "mismatch clear");
    lbl(8'h01, 3);
    chk_bit(payload_mismatch_anomaly, 1'b0, "non-specific");
    lbl(8'h22, 3);
    chk_bit(payload_mismatch_anomaly, 1'b1, "mismatch");
    cyc(1);
    chk_bit(payload_mismatch_defect, 1'b1, "mismatch set");
    trail_fail_in = 1'b1;
    cyc(1);
    chk_bit(payload_mismatch_defect, 1'b0, "trail fail");
    trail_fail_in = 1'b0;
    cyc(1);
    chk_bit(payload_mismatch_defect, 1'b1, "trail fail gone");
  endtask

  // ============================================================
  // Main sequence and watchdog
  // ============================================================
  initial begin
    {arst_n, signal_loss_anomaly, block_error_anomaly, block_end, second_tick} = '0;
    {second_bad, server_fail_in, line_coded_mode, label_frame, trail_fail_in, slow} = '0;
    {run, loss} = '0;
    clk_en = 1'b1;
    deg_m = 4'h2;
    label_m = 4'h3;
    path_signal_label = 8'h00;
    expected_label = 8'h13;
    fail_count = 0;
    n_tests = 0;
    cyc(2);
    chk_bit(frame_loss_defect, 1'b1, "reset frame");
    arst_n = 1'b1;
    cyc(1);
    chk_bit(justif_loss_defect, 1'b1, "reset justif");
    chk_bit(frame_loss_defect, 1'b1, "reset frame");
    chk_lbl(accepted_label, 8'h00, "reset label");
    t_los();
    t_blk();
    t_deg();
    t_align(1);
    t_align(0);
    t_line();
    t_ais();
    t_label();
    summarize();
  end

  initial begin
    #25000;
    fail_count++;
    summarize();
  end
endmodule

`default_nettype wire
